// ### rtl/p1mux_defines.svh
// constants for the port 1 pin function multiplexer
`ifndef P1MUX_DEFINES_SVH
`define P1MUX_DEFINES_SVH
`define P1MUX_NPINS        8
`define P1MUX_ADR_DIR      4'h0
`define P1MUX_ADR_SEL      4'h1
`define P1MUX_ADR_SUPIN    4'h2
`define P1MUX_ADR_AEN      4'h3
`define P1MUX_ADR_CMPDIS   4'h4
`define P1MUX_ADR_OUT      4'h5
`define P1MUX_ADR_IN       4'h6
`define P1MUX_ADR_FUSE     4'h7
`define P1MUX_ADR_STATUS   4'h8
`define P1MUX_RST_BYTE     8'h00
`define P1MUX_FUSE_KEY     8'hA5
`define P1MUX_ST_JTAG      0
`define P1MUX_ST_FUSE      1
`define P1MUX_ST_JREQ      2
`endif

// ### rtl/p1mux_pkg.sv
// types for the port 1 pin function multiplexer
package p1mux_pkg;
	typedef enum logic [1:0] {
		P1MUX_BUS_IDLE,
		P1MUX_BUS_ANSWER
	} p1mux_bus_state_t;
endpackage : p1mux_pkg

// ### rtl/p1mux_sync.sv
// two flip-flop synchroniser for pin inputs
module p1mux_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} p1mux_sync_state_t;

	p1mux_sync_state_t s_q;
	p1mux_sync_state_t s_d;

	initial begin
		if (WIDTH < 1) begin
			$error("p1mux_sync: WIDTH must be positive");
		end
	end

	// first stage feeds only the second stage
	always_comb begin
		s_d        = s_q;
		s_d.meta   = async_in;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule : p1mux_sync

// ### rtl/p1mux_top.sv
// port 1 pin function multiplexer with avalon-mm control registers
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`include "p1mux_defines.svh"
module p1mux_top #(
	parameter int NPINS = `P1MUX_NPINS
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [3:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	input  wire logic [3:0]       avs_byteenable,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             jtag_mode_req,
	input  wire logic [NPINS-1:0] pin_in,
	output logic      [NPINS-1:0] pin_out,
	output logic      [NPINS-1:0] pin_oe,
	output logic      [NPINS-1:0] analog_connect,
	output logic                  timer_ext_clock_in,
	output logic                  capture_in_ch0,
	output logic                  capture_in_ch1,
	input  wire logic             timer_out_ch0,
	input  wire logic             timer_out_ch1,
	input  wire logic             sub_main_clock_out,
	input  wire logic             converter_clock_out,
	input  wire logic             aux_clock_out,
	input  wire logic [NPINS-1:0] serial_pin_out,
	input  wire logic [NPINS-1:0] serial_pin_oe,
	output logic      [NPINS-1:0] serial_pin_in,
	output logic                  jtag_active,
	output logic                  jtag_bypass,
	output logic                  debug_access_en,
	output logic                  jtag_tck,
	output logic                  jtag_tms,
	output logic                  jtag_tdi,
	input  wire logic             jtag_tdo
);
	import p1mux_pkg::*;

	initial begin
		if (NPINS != 8) begin
			$error("p1mux_top: pin map is fixed at eight pins");
		end
	end

	// ********************************
	// state
	// ********************************
	typedef struct packed {
		p1mux_bus_state_t bus;
		logic [31:0]      rdata;
		logic [7:0]       dir;
		logic [7:0]       sel;
		logic [7:0]       supin;
		logic [7:0]       aen;
		logic [7:0]       cmpdis;
		logic [7:0]       outv;
		logic             fuse;
		logic [7:0]       pins;
		logic             tcap0;
		logic             tcap1;
		logic             tclk;
		logic [7:0]       sin;
		logic             jtck;
		logic             jtms;
		logic             jtdi;
	} p1mux_state_t;

	p1mux_state_t s_q;
	p1mux_state_t s_d;
	logic [7:0]   pin_s;
	logic         jreq_s;

	p1mux_sync #(.WIDTH(9)) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in ({jtag_mode_req, pin_in}),
		.sync_out ({jreq_s, pin_s})
	);

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		merge_byte = be[0] ? wd[7:0] : old;
	endfunction : merge_byte

	// ********************************
	// pin function selection
	// ********************************
	logic       jmode;
	logic [7:0] fn_out;
	logic [7:0] fn_oe;
	logic [7:0] in_en;

	assign jmode = jreq_s & ~s_q.fuse;

	always_comb begin
		fn_out = s_q.outv;
		fn_oe  = s_q.dir;
		in_en  = ~s_q.sel & ~s_q.dir;
		for (int i = 0; i < 8; i++) begin
			if (s_q.sel[i]) begin
				fn_oe[i]  = 1'b0;
				fn_out[i] = 1'b0;
			end
		end
		// pin 0: external clock in or aux clock out
		if (s_q.sel[0] && s_q.dir[0]) begin
			fn_oe[0]  = 1'b1;
			fn_out[0] = aux_clock_out;
		end
		// pins 1 and 2: compare outputs when driving
		if (s_q.sel[1] && s_q.dir[1]) begin
			fn_oe[1]  = 1'b1;
			fn_out[1] = timer_out_ch0;
		end
		if (s_q.sel[2] && s_q.dir[2]) begin
			fn_oe[2]  = 1'b1;
			fn_out[2] = timer_out_ch1;
		end
		if (s_q.sel[3] && s_q.dir[3] && !s_q.cmpdis[3]) begin
			fn_oe[3]  = 1'b1;
			fn_out[3] = converter_clock_out;
		end
		if (s_q.sel[4] && s_q.dir[4]) begin
			fn_oe[4]  = 1'b1;
			fn_out[4] = sub_main_clock_out;
		end
		if (s_q.sel[5] && s_q.dir[5]) begin
			fn_oe[5]  = 1'b1;
			fn_out[5] = timer_out_ch0;
		end
		if (s_q.sel[6] && s_q.dir[6]) begin
			fn_oe[6]  = 1'b1;
			fn_out[6] = timer_out_ch1;
		end
		// serial unit beats select and direction on pins 5..7
		for (int i = 5; i < 8; i++) begin
			if (s_q.supin[i]) begin
				fn_oe[i]  = serial_pin_oe[i];
				fn_out[i] = serial_pin_out[i];
			end
		end
		// comparator path disconnects the output enable and the IN register read of pin 3; serial_pin_in[3] still follows the pin
		if (s_q.cmpdis[3]) begin
			fn_oe[3] = 1'b0;
			in_en[3] = 1'b0;
		end
		// analog enable overrides every digital setting except jtag mode on pins 4..7
		for (int i = 0; i < 8; i++) begin
			if (s_q.aen[i]) begin
				fn_oe[i]  = 1'b0;
				fn_out[i] = 1'b0;
				in_en[i]  = 1'b0;
			end
		end
		// jtag pins 4..7 take top priority
		if (jmode) begin
			fn_oe[4]  = 1'b0;
			fn_oe[5]  = 1'b0;
			fn_oe[6]  = 1'b0;
			fn_oe[7]  = 1'b1;
			fn_out[4] = 1'b0;
			fn_out[5] = 1'b0;
			fn_out[6] = 1'b0;
			fn_out[7] = jtag_tdo;
		end
	end

	// ********************************
	// next state and register bus
	// ********************************
	always_comb begin
		s_d       = s_q;
		s_d.pins  = pin_s;
		s_d.tclk  = s_q.sel[0] & ~s_q.dir[0] & ~s_q.aen[0] & pin_s[0];
		s_d.tcap0 = s_q.sel[1] & ~s_q.dir[1] & ~s_q.aen[1] & pin_s[1];
		s_d.tcap1 = s_q.sel[2] & ~s_q.dir[2] & ~s_q.aen[2] & pin_s[2];
		s_d.sin   = s_q.supin & ~s_q.aen & pin_s & {8{~jmode}};
		s_d.jtck  = jmode & pin_s[4];
		s_d.jtms  = jmode & pin_s[5];
		s_d.jtdi  = jmode & pin_s[6];
		unique case (s_q.bus)
			P1MUX_BUS_IDLE: begin
				if (avs_write) begin
					s_d.bus = P1MUX_BUS_ANSWER;
					unique case (avs_address)
						`P1MUX_ADR_DIR:    s_d.dir    = merge_byte(s_q.dir, avs_writedata, avs_byteenable);
						`P1MUX_ADR_SEL:    s_d.sel    = merge_byte(s_q.sel, avs_writedata, avs_byteenable);
						`P1MUX_ADR_SUPIN:  s_d.supin  = merge_byte(s_q.supin, avs_writedata, avs_byteenable);
						`P1MUX_ADR_AEN:    s_d.aen    = merge_byte(s_q.aen, avs_writedata, avs_byteenable);
						`P1MUX_ADR_CMPDIS: s_d.cmpdis = merge_byte(s_q.cmpdis, avs_writedata, avs_byteenable);
						`P1MUX_ADR_OUT:    s_d.outv   = merge_byte(s_q.outv, avs_writedata, avs_byteenable);
						`P1MUX_ADR_FUSE: begin
							// one-way: nothing but reset clears it
							if (avs_byteenable[0] && avs_writedata[7:0] == `P1MUX_FUSE_KEY) begin
								s_d.fuse = 1'b1;
							end
						end
						default: begin
						end
					endcase
				end else if (avs_read) begin
					s_d.bus   = P1MUX_BUS_ANSWER;
					s_d.rdata = '0;
					unique case (avs_address)
						`P1MUX_ADR_DIR:    s_d.rdata[7:0] = s_q.dir;
						`P1MUX_ADR_SEL:    s_d.rdata[7:0] = s_q.sel;
						`P1MUX_ADR_SUPIN:  s_d.rdata[7:0] = s_q.supin;
						`P1MUX_ADR_AEN:    s_d.rdata[7:0] = s_q.aen;
						`P1MUX_ADR_CMPDIS: s_d.rdata[7:0] = s_q.cmpdis;
						`P1MUX_ADR_OUT:    s_d.rdata[7:0] = s_q.outv;
						`P1MUX_ADR_IN:     s_d.rdata[7:0] = s_q.pins & in_en;
						`P1MUX_ADR_FUSE:   s_d.rdata[0]   = s_q.fuse;
						`P1MUX_ADR_STATUS: begin
							s_d.rdata[`P1MUX_ST_JTAG] = jmode;
							s_d.rdata[`P1MUX_ST_FUSE] = s_q.fuse;
							s_d.rdata[`P1MUX_ST_JREQ] = jreq_s;
						end
						default: begin
						end
					endcase
				end
			end
			P1MUX_BUS_ANSWER: begin
				s_d.bus = P1MUX_BUS_IDLE;
			end
			default: begin
				s_d.bus = P1MUX_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q        <= '0;
			s_q.bus    <= P1MUX_BUS_IDLE;
			s_q.dir    <= `P1MUX_RST_BYTE;
			s_q.sel    <= `P1MUX_RST_BYTE;
			s_q.supin  <= `P1MUX_RST_BYTE;
			s_q.aen    <= `P1MUX_RST_BYTE;
			s_q.cmpdis <= `P1MUX_RST_BYTE;
			s_q.outv   <= `P1MUX_RST_BYTE;
		end else begin
			s_q <= s_d;
		end
	end

	// ********************************
	// outputs
	// ********************************
	// waitrequest drops in the answer cycle; one wait state keeps read data registered
	assign avs_waitrequest    = (avs_read | avs_write) & (s_q.bus != P1MUX_BUS_ANSWER);
	assign avs_readdata       = s_q.rdata;
	assign pin_out            = fn_out;
	assign pin_oe             = fn_oe;
	assign analog_connect     = s_q.aen;
	assign timer_ext_clock_in = s_q.tclk;
	assign capture_in_ch0     = s_q.tcap0;
	assign capture_in_ch1     = s_q.tcap1;
	assign serial_pin_in      = s_q.sin;
	assign jtag_active        = jmode;
	assign jtag_bypass        = s_q.fuse;
	assign debug_access_en    = ~s_q.fuse;
	assign jtag_tck           = s_q.jtck;
	assign jtag_tms           = s_q.jtms;
	assign jtag_tdi           = s_q.jtdi;
endmodule : p1mux_top

// ### test/p1mux_board.sv
// board-side model of what hangs on the port 1 pins
// ************
// board model
// ************
module p1mux_board (
	input  wire logic       ref_clk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] board_val,
	input  wire logic [7:0] board_en,
	output logic      [7:0] pin_in
);
	// no pull resistors: an undriven line wanders, it does not keep its level
	logic [7:0] wander_q = 8'h55;
	always @(posedge ref_clk) wander_q <= ~wander_q;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_en & board_val)
		| (~pin_oe & ~board_en & wander_q);
endmodule : p1mux_board

// ### test/p1mux_monitor.sv
// concurrent checks on the port 1 pin mux ports
// ************
// checker
// ************
module p1mux_monitor #(
	parameter int NPINS = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic             avs_waitrequest,
	input  wire logic [NPINS-1:0] pin_out,
	input  wire logic [NPINS-1:0] pin_oe,
	input  wire logic [NPINS-1:0] analog_connect,
	input  wire logic             timer_ext_clock_in,
	input  wire logic             capture_in_ch0,
	input  wire logic             jtag_active,
	input  wire logic             jtag_bypass,
	input  wire logic             debug_access_en,
	input  wire logic             jtag_tck,
	input  wire logic             jtag_tdo
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer late");
	fuse_lock_a: assert property (jtag_bypass
		|-> !debug_access_en && !jtag_active) else $error("access after fuse");
	fuse_keep_a: assert property (jtag_bypass
		|=> jtag_bypass) else $error("fuse cleared");
	analog_off_a: assert property (
		(analog_connect[3:0] & pin_oe[3:0]) == 4'h0) else $error("analog pin driven");
	jtag_in_a: assert property (jtag_active
		|-> pin_oe[6:4] == 3'h0) else $error("jtag input driven");
	jtag_out_a: assert property (jtag_active
		|-> pin_oe[7] && pin_out[7] == jtag_tdo) else $error("tdo not on pin");
	// four idle cycles cover the single register stage before tck is cleared
	tck_idle_a: assert property (!jtag_active [*4]
		|-> !jtag_tck) else $error("tck outside jtag");
	tclk_off_a: assert property (pin_oe[0] [*3]
		|-> !timer_ext_clock_in) else $error("timer clock while output");
	cap_off_a: assert property (pin_oe[1] [*3]
		|-> !capture_in_ch0) else $error("capture while output");
	c_jtag: cover property (jtag_active && pin_oe[7]);
	c_fuse: cover property (jtag_bypass);
	c_analog: cover property (analog_connect[0]);
endmodule : p1mux_monitor
bind p1mux_top p1mux_monitor #(.NPINS(NPINS)) u_mon (.*);

// ### test/tb_p1mux_top.sv
// self-checking bench for the port 1 pin mux
// ************
// bench
// ************
module tb_p1mux_top;
	timeunit 1ns;
	timeprecision 1ps;
	import p1mux_pkg::*;
	logic        ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
	logic [3:0]  avs_address = '0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = '0, avs_readdata, rdv;
	logic        avs_waitrequest, timer_ext_clock_in, capture_in_ch0, capture_in_ch1;
	logic        jtag_active, jtag_bypass, debug_access_en, jtag_tck, jtag_tms, jtag_tdi;
	logic        jtag_mode_req = 0, jtag_tdo = 0, timer_out_ch0 = 0, timer_out_ch1 = 0;
	logic        sub_main_clock_out = 0, converter_clock_out = 0, aux_clock_out = 0;
	logic [7:0]  pin_in, pin_out, pin_oe, analog_connect, serial_pin_in;
	logic [7:0]  serial_pin_out = '0, serial_pin_oe = '0, board_val = '0, board_en = 8'hFF;
	int          n_mismatch = 0, n_tests = 0;
	p1mux_top DUT (.*);
	p1mux_board u_board (.*);
	always #5 ref_clk = ~ref_clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// look at waitrequest as it stands at each rising edge, take data there
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (!avs_waitrequest) begin
				rdv = avs_readdata;
				break;
			end
		end
		if (n == 50) begin
			n_mismatch++;
			print_verdict();
		end
		avs_write <= 0;
		avs_read <= 0;
	endtask : bus
	// fresh peripheral and board levels, then wait out the pin sync stages
	task automatic drive();
		@(posedge ref_clk);
		{timer_out_ch0, timer_out_ch1, sub_main_clock_out, converter_clock_out,
			aux_clock_out, jtag_tdo} <= 6'($urandom);
		board_val <= 8'($urandom);
		serial_pin_out <= 8'($urandom);
		serial_pin_oe <= 8'($urandom);
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : drive
	// pins 0..6 with every select bit set and no serial or analog enable
	function automatic logic [15:0] alt_pins(input logic [7:0] dir);
		logic [7:0] o;
		o = {1'b0, timer_out_ch1, timer_out_ch0, sub_main_clock_out, converter_clock_out,
			timer_out_ch1, timer_out_ch0, aux_clock_out};
		return {dir, o & dir};
	endfunction : alt_pins
	initial begin
		int         i;
		logic [7:0] d, e;
		void'($urandom(53651));
		repeat (8) @(posedge ref_clk);
		rst_n <= 1;
		bus(0, 4'h0, 0);
		chk("dir reset", 0, rdv);
		bus(0, 4'hF, 0);
		chk("unmapped", 0, rdv);
		for (i = 0; i < 6; i++) begin
			d = 8'($urandom);
			e = 8'($urandom);
			bus(1, 4'h0, {24'h0, d});
			bus(1, 4'h5, {24'h0, e});
			drive();
			chk("gpio oe", d, pin_oe);
			chk("gpio out", d & e, pin_out & d);
			bus(0, 4'h6, 0);
			chk("gpio in", ~d & board_val, rdv[7:0] & ~d);
		end
		bus(1, 4'h1, 32'h7F);
		for (i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : 8'($urandom) & 8'h7F;
			bus(1, 4'h0, {24'h0, d});
			drive();
			chk("alt pins", alt_pins(d), {pin_oe & 8'h7F, pin_out & d});
			chk("tclk", ~d[0] & board_val[0], timer_ext_clock_in);
			chk("cap0", ~d[1] & board_val[1], capture_in_ch0);
			chk("cap1", ~d[2] & board_val[2], capture_in_ch1);
		end
		bus(1, 4'h2, 32'hE0);
		drive();
		chk("serial oe", serial_pin_oe[6:5], pin_oe[6:5]);
		chk("serial in", 8'hE0 & ((serial_pin_oe & serial_pin_out) | (~serial_pin_oe & board_val)), serial_pin_in);
		bus(1, 4'h2, 0);
		bus(1, 4'h0, 32'hFF);
		bus(1, 4'h3, 32'h0F);
		drive();
		chk("analog", 8'h0F, analog_connect);
		chk("analog oe", 0, pin_oe & 8'h0F);
		@(posedge ref_clk);
		jtag_mode_req <= 1;
		drive();
		chk("jtag", 8'h80, {jtag_active, pin_oe[6:4], 4'h0});
		chk("jtag in", board_val[6:4], {jtag_tdi, jtag_tms, jtag_tck});
		chk("tdo", jtag_tdo, pin_out[7]);
		@(posedge ref_clk);
		jtag_mode_req <= 0;
		bus(1, 4'h7, 32'hA5);
		bus(0, 4'h7, 0);
		chk("fuse", 1, rdv[0]);
		@(posedge ref_clk);
		jtag_mode_req <= 1;
		drive();
		chk("locked", 3'h2, {jtag_active, jtag_bypass, debug_access_en});
		chk("p4 oe", 1, pin_oe[4]);
		print_verdict();
	end
endmodule : tb_p1mux_top
